// *** logic/mrb_pkg.sv ***
`default_nettype none
package mrb_pkg;
	localparam int          NUM_REGIONS   = 16;
	localparam logic [7:0]  OFS_SELECT    = 8'h00;
	localparam logic [7:0]  OFS_BASE      = 8'h04;
	localparam logic [7:0]  OFS_ATTR      = 8'h08;
	localparam logic [7:0]  OFS_FSTATUS   = 8'h0C;
	localparam logic [7:0]  OFS_FADDR     = 8'h10;
	localparam int          BASE_LSB      = 5;
	localparam int          VALID_BIT     = 4;
	localparam int          NOEXEC_BIT    = 28;
	localparam int          PERM_LSB      = 24;
	localparam int          SUBOFF_LSB    = 8;
	localparam int          SIZE_LSB      = 1;
	localparam int          ENABLE_BIT    = 0;
	localparam logic [31:0] ATTR_WMASK    = 32'h173FFF3F;
	localparam logic [4:0]  SIZE_MIN      = 5'h04;
	localparam logic [4:0]  SIZE_FULL     = 5'h1F;
	localparam logic [4:0]  SIZE_SUB_MIN  = 5'h07;
	localparam logic [7:0]  SELECT_RST    = 8'h00;
	localparam logic [31:0] ATTR_RST      = 32'h00000000;
	localparam logic [26:0] BASE_RST      = 27'h0000000;
	localparam int          FST_INSTR_BIT = 0;
	localparam int          FST_DATA_BIT  = 1;
	localparam int          FST_ADDR_BIT  = 7;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        priv;
		logic        write;
		logic        fetch;
	} mrb_access_s;

	typedef struct packed {
		logic        addr_valid;
		logic        data_viol;
		logic        instr_viol;
	} mrb_fault_s;
endpackage : mrb_pkg
`default_nettype wire

// *** logic/mrb_region_regs.sv ***
// Behaviour
// - base and attribute act on selected region
// - valid base write retargets the selector
// - invalid base write keeps selection, drops field
// - valid bit always reads zero
// - low base bits read the selector
// - base above N, reserved below read zero
// - 32-byte region base spans bits 31:5
// - 4-gigabyte region ignores base, covers all
// - base size-aligned; compare only bits above N
// - attributes high halfword, size/enables low
// - no-execute bit forbids instruction fetches
// - permission code sets read/write rights
// - type extension, cacheable, bufferable, shareable bits
// - subregion mask bit one disables subregion
// - region size is two to size plus one
// - permission code table decoding
// - violation raises fault and records cause
// - selector accepts only implemented region numbers
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mrb_region_regs
	import mrb_pkg::*;
(
	input  wire logic        pclk,          // Core clock
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [7:0]  paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	input  wire logic [3:0]  pstrb,         // APB write strobes
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire mrb_access_s access_req,    // Access to be checked
	output logic             access_fault,  // Violation pulse
	output mrb_fault_s       fault_status   // Sticky fault status
);
	logic [7:0]  region_selector_ff;
	logic [26:0] base_ff [NUM_REGIONS];
	logic [31:0] attr_ff [NUM_REGIONS];
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        fault_ff;
	mrb_fault_s  fst_ff;
	logic [31:0] faddr_ff;
	logic        nxt_fault;
	logic        nxt_instr;
	logic        nxt_data;
	logic        setup;
	logic        wr_done;
	logic        bad_strb;
	logic        mapped;
	logic [31:0] nxt_rdata;
	logic [3:0]  cur;

	// Address bits kept by a region of the given size; none for full map.
	function automatic logic [31:0] size_mask(input logic [4:0] size);
		logic [5:0] n;
		n = 6'(size) + 6'h01;
		if (size == SIZE_FULL)
			size_mask = 32'h00000000;
		else
			size_mask = 32'hFFFFFFFF << n;
	endfunction : size_mask

	function automatic logic perm_ok(input logic [2:0] code, input logic priv,
		input logic write);
		case (code)
			3'h0:    perm_ok = 1'b0;
			3'h1:    perm_ok = priv;
			3'h2:    perm_ok = priv | !write;
			3'h3:    perm_ok = 1'b1;
			3'h5:    perm_ok = priv & !write;
			3'h6:    perm_ok = !write;
			3'h7:    perm_ok = !write;
			default: perm_ok = 1'b0; // Reserved code: treated as no access.
		endcase
	endfunction : perm_ok

	assign cur      = region_selector_ff[3:0];
	assign setup    = psel & !penable;
	assign wr_done  = psel & penable & pready_ff & pwrite & !pslverr_ff;
	assign mapped   = (paddr == OFS_SELECT) || (paddr == OFS_BASE) ||
		(paddr == OFS_ATTR) || (paddr == OFS_FSTATUS) ||
		(paddr == OFS_FADDR);
	// Partial writes to the attribute word are refused rather than merged.
	assign bad_strb = pwrite && (paddr == OFS_ATTR) && (pstrb != 4'hF);

	always_comb begin
		nxt_rdata = 32'h00000000;
		case (paddr)
			OFS_SELECT:  nxt_rdata = {24'h000000, region_selector_ff};
			OFS_BASE:    nxt_rdata = ({base_ff[cur], 5'h00} &
				size_mask(attr_ff[cur][SIZE_LSB +: 5])) |
				{28'h0000000, cur};
			OFS_ATTR:    nxt_rdata = attr_ff[cur];
			OFS_FSTATUS: nxt_rdata = {24'h000000, fst_ff.addr_valid, 5'h00,
				fst_ff.data_viol, fst_ff.instr_viol};
			OFS_FADDR:   nxt_rdata = faddr_ff;
			default:     nxt_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h00000000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup & (!mapped | bad_strb);
			if (setup && !pwrite)
				prdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			region_selector_ff <= SELECT_RST;
		end else if (wr_done && paddr == OFS_SELECT) begin
			if (pwdata[7:0] < 8'(NUM_REGIONS))
				region_selector_ff <= pwdata[7:0];
		end else if (wr_done && paddr == OFS_BASE && pwdata[VALID_BIT]) begin
			region_selector_ff <= {4'h0, pwdata[3:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				base_ff[i] <= BASE_RST;
				attr_ff[i] <= ATTR_RST;
			end
		end else if (wr_done) begin
			if (paddr == OFS_BASE) begin
				if (pwdata[VALID_BIT])
					base_ff[pwdata[3:0]] <= pwdata[31:BASE_LSB];
				else
					base_ff[cur] <= pwdata[31:BASE_LSB];
			end
			if (paddr == OFS_ATTR)
				attr_ff[cur] <= pwdata & ATTR_WMASK;
		end
	end

	// Highest numbered matching region wins, as overlapping regions expect.
	always_comb begin
		logic [31:0] m;
		logic [4:0]  sz;
		logic [31:0] a;
		logic [2:0]  sub;
		logic [5:0]  sh;
		logic        hit;
		logic        xn;
		logic [2:0]  code;
		m    = 32'h00000000;
		sz   = 5'h00;
		a    = 32'h00000000;
		sub  = 3'h0;
		sh   = 6'h00;
		hit  = 1'b0;
		xn   = 1'b0;
		code = 3'h0;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			a  = attr_ff[i];
			sz = a[SIZE_LSB +: 5];
			m  = size_mask(sz);
			sh = 6'(sz) - 6'h02;
			sub = 3'(access_req.addr >> sh);
			// Sizes below the minimum are never matched.
			if (a[ENABLE_BIT] && sz >= SIZE_MIN &&
				((access_req.addr & m) == ({base_ff[i], 5'h00} & m)) &&
				!(sz >= SIZE_SUB_MIN && a[SUBOFF_LSB + 32'(sub)])) begin
				hit  = 1'b1;
				xn   = a[NOEXEC_BIT];
				code = a[PERM_LSB +: 3];
			end
		end
		nxt_instr = access_req.valid & hit & access_req.fetch &
			(xn | !perm_ok(code, access_req.priv, 1'b0));
		nxt_data  = access_req.valid & hit & !access_req.fetch &
			!perm_ok(code, access_req.priv, access_req.write);
		nxt_fault = nxt_instr | nxt_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff <= 1'b0;
			fst_ff   <= '0;
			faddr_ff <= 32'h00000000;
		end else begin
			fault_ff <= nxt_fault;
			// Write one to clear; a fault in the same cycle wins.
			if (wr_done && paddr == OFS_FSTATUS) begin
				if (pwdata[FST_INSTR_BIT])
					fst_ff.instr_viol <= 1'b0;
				if (pwdata[FST_DATA_BIT])
					fst_ff.data_viol <= 1'b0;
				if (pwdata[FST_ADDR_BIT])
					fst_ff.addr_valid <= 1'b0;
			end
			if (nxt_instr)
				fst_ff.instr_viol <= 1'b1;
			if (nxt_data) begin
				fst_ff.data_viol  <= 1'b1;
				fst_ff.addr_valid <= 1'b1;
				faddr_ff          <= access_req.addr;
			end
		end
	end

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign access_fault = fault_ff;
	assign fault_status = fst_ff;
endmodule : mrb_region_regs
`default_nettype wire

// *** tb/mrb_region_regs_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module mrb_region_regs_properties
	import mrb_pkg::*;
(
	input wire logic        pclk,         // Clock
	input wire logic        presetn,      // Reset
	input wire logic        psel,         // Select
	input wire logic        penable,      // Enable
	input wire logic        pwrite,       // Direction
	input wire logic [7:0]  paddr,        // Address
	input wire logic [31:0] pwdata,       // Write data
	input wire logic [3:0]  pstrb,        // Strobes
	input wire logic [31:0] prdata,       // Read data
	input wire logic        pready,       // Ready
	input wire logic        pslverr,      // Error
	input wire mrb_access_s access_req,   // Checked access
	input wire logic        access_fault, // Fault pulse
	input wire mrb_fault_s  fault_status  // Fault status
);
	// The selector is tracked from the bus alone, so a stale update shows.
	logic [3:0] sel_ff;
	logic       commit;
	logic       wr_sel;
	logic       wr_base;
	assign commit = psel && penable && pready && pwrite && !pslverr;
	assign wr_sel = commit && paddr == OFS_SELECT && pwdata[7:4] == 4'h0;
	assign wr_base = commit && paddr == OFS_BASE && pwdata[4];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff <= 4'h0;
		end else if (wr_sel || wr_base) begin
			sel_ff <= pwdata[3:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_valid_zero;
		pready && !pwrite && paddr == OFS_BASE |-> !prdata[4]; endproperty
	a_valid_zero: assert property (p_valid_zero) else $error("valid");
	property p_region_read;
		pready && !pwrite && paddr == OFS_BASE |-> prdata[3:0] == sel_ff;
	endproperty
	a_region_read: assert property (p_region_read) else $error("sel");
	property p_attr_resv; pready && !pwrite && paddr == OFS_ATTR
		|-> (prdata & 32'hE8C000C0) == 32'h0; endproperty
	a_attr_resv: assert property (p_attr_resv) else $error("resv");
	property p_unmapped; psel && !penable && paddr > 8'h10 |=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmap");
	property p_strobe; psel && !penable && pwrite && paddr == OFS_ATTR
		&& pstrb != 4'hF |=> pslverr; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe");
	property p_fault_cause; access_fault |-> $past(access_req.valid);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("cause");
	property p_fault_status;
		access_fault |-> fault_status.data_viol || fault_status.instr_viol;
	endproperty
	a_fault_status: assert property (p_fault_status) else $error("fs");
endmodule : mrb_region_regs_properties
bind mrb_region_regs mrb_region_regs_properties u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .access_req(access_req),
	.access_fault(access_fault), .fault_status(fault_status));
`default_nettype wire

// *** tb/test_mrb_region_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_mrb_region_regs import mrb_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        access_fault;
	mrb_access_s access_req;
	mrb_fault_s  fault_status;
	int          fail_count, n_compared;
	mrb_region_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.access_req(access_req), .access_fault(access_fault),
		.fault_status(fault_status));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin fail_count++; end_sim(); end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 4'h0);
		`CHK(rd, x)
	endtask : rdc
	task acc(input logic [31:0] ad, input logic p, w, f, x);
		@(posedge pclk);
		access_req <= '{valid: 1'b1, addr: ad, priv: p, write: w, fetch: f};
		@(posedge pclk);
		access_req.valid <= 1'b0;
		#1 `CHK(access_fault, x)
	endtask : acc
	task t_base;
		wr(OFS_SELECT, 32'h3);
		wr(OFS_ATTR, 32'h03000009);
		wr(OFS_BASE, 32'h10000025);
		rdc(OFS_BASE, 32'h10000023);
		wr(OFS_SELECT, 32'h7);
		wr(OFS_ATTR, 32'h01000013);
		wr(OFS_SELECT, 32'h2);
		wr(OFS_BASE, 32'h200003F7);
		rdc(OFS_SELECT, 32'h7);
		rdc(OFS_BASE, 32'h20000007);
		rdc(OFS_ATTR, 32'h01000013);
		wr(OFS_ATTR, 32'h0300003F);
		rdc(OFS_BASE, 32'h00000007);
		wr(OFS_ATTR, 32'h01000009);
		rdc(OFS_BASE, 32'h200003E7);
		wr(OFS_SELECT, 32'h10);
		rdc(OFS_SELECT, 32'h7);
	endtask : t_base
	task t_attr;
		apb(1'b1, OFS_ATTR, 32'hFFFFFFFF, 4'h3);
		`CHK(er, 1'b1)
		rdc(OFS_ATTR, 32'h01000009);
		wr(OFS_ATTR, 32'hFFFFFFFF);
		rdc(OFS_ATTR, 32'h173FFF3F);
		wr(OFS_ATTR, 32'h01000009);
		rdc(8'h20, 32'h0);
		`CHK(er, 1'b1)
	endtask : t_attr
	task t_fault;
		acc(32'h200003E4, 1'b0, 1'b0, 1'b0, 1'b1);
		`CHK(fault_status.data_viol, 1'b1)
		acc(32'h200003E4, 1'b1, 1'b1, 1'b0, 1'b0);
		acc(32'h20000400, 1'b0, 1'b0, 1'b0, 1'b0);
		wr(OFS_ATTR, 32'h13000009);
		acc(32'h200003E4, 1'b1, 1'b0, 1'b1, 1'b1);
		`CHK(fault_status.instr_viol, 1'b1)
		rdc(OFS_FSTATUS, 32'h00000083);
		rdc(OFS_FADDR, 32'h200003E4);
		wr(OFS_FSTATUS, 32'h00000083);
		rdc(OFS_FSTATUS, 32'h00000000);
	endtask : t_fault
	// Region 5 is 256 bytes with no access; its subregion 1 is switched off.
	task t_sub;
		wr(OFS_BASE, 32'h40000015);
		rdc(OFS_SELECT, 32'h5);
		wr(OFS_ATTR, 32'h0000020F);
		acc(32'h40000000, 1'b1, 1'b0, 1'b0, 1'b1);
		acc(32'h40000020, 1'b1, 1'b0, 1'b0, 1'b0);
	endtask : t_sub
	initial begin
		{psel, penable, pwrite, presetn, paddr, pwdata, pstrb} = '0;
		access_req = '0;
		fail_count = 0;
		n_compared = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_base();
		t_attr();
		t_fault();
		t_sub();
		end_sim();
	end
endmodule : test_mrb_region_regs
`default_nettype wire
